// *** shared/irq_ctrl_defines.svh ***
`ifndef IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_DEFINES_SVH

// special function register addresses
`define ADDR_IRQ_ENABLE_MAIN       8'hA8
`define ADDR_IRQ_PRIORITY_MAIN     8'hB8
`define ADDR_PORT_IRQ_REQ_FLAGS    8'hC0
`define ADDR_IRQ_ENABLE_PORT_ADC   8'hE8
`define ADDR_PORT_IRQ_POLARITY     8'hE9
`define ADDR_IRQ_PRIORITY_PORT_ADC 8'hF8

// reset values
`define RST_REG8                   8'h00

// main register bit positions
`define BIT_GLOBAL_IRQ_GATE        7

// vector base and step
`define VEC_BASE                   16'h0003
`define VEC_STEP_SHIFT             3

// source count
`define NUM_SOURCES                15
`define NUM_PORT_LINES             7

`endif

// *** shared/irq_ctrl_pkg.sv ***
package irq_ctrl_pkg;

    // source index: vector = base + index * 8
    typedef enum logic [3:0] {
        SRC_EXT0  = 4'h0,
        SRC_TMR0  = 4'h1,
        SRC_EXT1  = 4'h2,
        SRC_TMR1  = 4'h3,
        SRC_UART  = 4'h4,
        SRC_TWI   = 4'h5,
        SRC_TMR2  = 4'h6,
        SRC_EXT2  = 4'h7,
        SRC_EXT3  = 4'h8,
        SRC_EXT4  = 4'h9,
        SRC_EXT5  = 4'hA,
        SRC_EXT6  = 4'hB,
        SRC_EXT7  = 4'hC,
        SRC_EXT8  = 4'hD,
        SRC_ADC   = 4'hE
    } src_id_t;

    // register access from the core
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    // vector request toward the core
    typedef struct packed {
        logic        req;
        logic        high;
        logic [15:0] vector;
    } vec_req_t;

endpackage

// *** src/irq_ctrl.sv ***
`timescale 1ns/100ps
`include "irq_ctrl_defines.svh"
// Function
// [R1] fifteen request sources accepted
// [R2] fixed vector per source, 8-byte steps
// [R3] per-source enable blocks vectoring
// [R4] global gate bit 7 blocks everything; the code blocks only vector requests, and port flags and wake_out still rise
// [R5] main enable bit order as listed
// [R6] second enable: adc, ext 8..2
// [R7] one priority bit per source
// [R8] second priority: adc, ext 8..2
// [R9] nesting: only high preempts low
// [R10] high level wins over low
// [R11] fixed polling order within level
// [R12] port lines level, held one cycle
// [R13] port request served next cycle
// [R14] polarity register selects active level
// [R15] flag set by hardware, cleared by software
// [R16] enabled port lines raise wake
// [R17] vector strobe, level held until return
// [R18] write zero clears, set wins
module irq_ctrl
(
    input  wire logic                  clk_in,
    input  wire logic                  rst_n_in,
    input  wire irq_ctrl_pkg::sfr_req_t sfr_in,
    input  wire logic                  ext0_req_in,
    input  wire logic                  ext1_req_in,
    input  wire logic                  tmr0_req_in,
    input  wire logic                  tmr1_req_in,
    input  wire logic                  tmr2_req_in,
    input  wire logic                  twowire_req_in,
    input  wire logic                  uart_req_in,
    input  wire logic                  adc_req_in,
    input  wire logic [6:0]            port_one_lines_in,
    input  wire logic                  vec_ack_in,
    input  wire logic                  reti_in,
    output logic [7:0]                 sfr_rdata_out,
    output logic                       sfr_hit_out,
    output irq_ctrl_pkg::vec_req_t     vec_out,
    output logic                       wake_out,
    output logic [1:0]                 active_level_out
);
    import irq_ctrl_pkg::*;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0]  irq_enable_main;
    logic [7:0]  irq_priority_main;
    logic [7:0]  port_irq_request_flags;
    logic [7:0]  irq_enable_port_adc;
    logic [7:0]  port_irq_polarity;
    logic [7:0]  irq_priority_port_adc;
    logic [6:0]  port_sync1;
    logic [6:0]  port_sync2;
    logic [6:0]  port_held;
    logic        high_active;
    logic        low_active;
    logic [14:0] pending;
    logic [14:0] enabled;
    logic [14:0] prio;
    logic [14:0] cand_high;
    logic [14:0] cand_low;
    logic [14:0] cand;
    logic        any_cand;
    logic        cand_is_high;
    logic [3:0]  win;
    logic        preempt_ok;
    logic [6:0]  port_active;
    logic [6:0]  port_set;
    logic        wr_flags;

    // polling order, highest first
    localparam logic [3:0] POLL [0:14] = '{
        4'h0, 4'h5, 4'hA, 4'h1, 4'h6, 4'hB, 4'h2, 4'h7,
        4'hC, 4'h3, 4'h8, 4'hD, 4'h4, 4'h9, 4'hE
    };

    // first source in polling order
    function automatic logic [3:0] poll_pick(input logic [14:0] req);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 14; i >= 0; i--)
        begin
            if (req[POLL[i]])
            begin
                r = POLL[i];
            end
        end
        return r;
    endfunction

    function automatic logic addr_is(input logic [7:0] a,
                                     input logic [7:0] b);
        return sfr_in.wr && (a == b);
    endfunction

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    // [R4] [R5] [R6] enable registers
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            irq_enable_main     <= `RST_REG8;
            irq_enable_port_adc <= `RST_REG8;
        end
        else
        begin
            if (addr_is(sfr_in.addr, `ADDR_IRQ_ENABLE_MAIN))
            begin
                irq_enable_main <= sfr_in.wdata;
            end
            if (addr_is(sfr_in.addr, `ADDR_IRQ_ENABLE_PORT_ADC))
            begin
                irq_enable_port_adc <= sfr_in.wdata;
            end
        end
    end

    // [R7] [R8] [R14] priority and polarity registers
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            irq_priority_main     <= `RST_REG8;
            irq_priority_port_adc <= `RST_REG8;
            port_irq_polarity     <= `RST_REG8;
        end
        else
        begin
            if (addr_is(sfr_in.addr, `ADDR_IRQ_PRIORITY_MAIN))
            begin
                irq_priority_main <= {1'b0, sfr_in.wdata[6:0]};
            end
            if (addr_is(sfr_in.addr, `ADDR_IRQ_PRIORITY_PORT_ADC))
            begin
                irq_priority_port_adc <= sfr_in.wdata;
            end
            if (addr_is(sfr_in.addr, `ADDR_PORT_IRQ_POLARITY))
            begin
                port_irq_polarity <= {1'b0, sfr_in.wdata[6:0]};
            end
        end
    end

    // ---------------------------------------------------------------
    // port lines
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            port_sync1 <= 7'h00;
            port_sync2 <= 7'h00;
            port_held  <= 7'h00;
        end
        else
        begin
            port_sync1 <= port_one_lines_in;
            port_sync2 <= port_sync1;
            port_held  <= port_active;
        end
    end

    // [R14] active level per polarity bit
    assign port_active = ~(port_sync2 ^ port_irq_polarity[6:0]);
    // [R12] held active across a whole cycle
    assign port_set    = port_active & port_held
                       & irq_enable_port_adc[6:0];
    assign wr_flags    = addr_is(sfr_in.addr, `ADDR_PORT_IRQ_REQ_FLAGS);

    // [R15] [R18] flags: set wins over software clear
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            port_irq_request_flags <= `RST_REG8;
        end
        else if (wr_flags)
        begin
            port_irq_request_flags <= {1'b0,
                (port_irq_request_flags[6:0] & sfr_in.wdata[6:0])
                | port_set};
        end
        else
        begin
            port_irq_request_flags <= {1'b0,
                port_irq_request_flags[6:0] | port_set};
        end
    end

    // [R16] wake from enabled port lines
    assign wake_out = |(port_active & irq_enable_port_adc[6:0]);

    // ---------------------------------------------------------------
    // arbitration
    // ---------------------------------------------------------------
    // [R1] fifteen sources in vector order
    // [R13] port flags are registered, served next cycle
    assign pending = {adc_req_in, port_irq_request_flags[6:0],
                      tmr2_req_in, twowire_req_in, uart_req_in,
                      tmr1_req_in, ext1_req_in, tmr0_req_in,
                      ext0_req_in};
    // [R3] [R5] [R6] per-source enables
    assign enabled = {irq_enable_port_adc[7], irq_enable_port_adc[6:0],
                      irq_enable_main[6:0]};
    // [R7] [R8] priority bits
    assign prio    = {irq_priority_port_adc[7],
                      irq_priority_port_adc[6:0],
                      irq_priority_main[6:0]};

    // [R4] global gate
    assign cand_high = (irq_enable_main[`BIT_GLOBAL_IRQ_GATE])
                     ? (pending & enabled & prio) : 15'h0000;
    assign cand_low  = (irq_enable_main[`BIT_GLOBAL_IRQ_GATE])
                     ? (pending & enabled & ~prio) : 15'h0000;
    // [R10] high level first
    assign cand_is_high = |cand_high;
    assign cand         = cand_is_high ? cand_high : cand_low;
    assign any_cand     = |cand;
    // [R11] polling order
    assign win          = poll_pick(cand);
    // [R9] nesting gate
    assign preempt_ok   = !high_active && (cand_is_high || !low_active);

    // [R17] [R2] vector request register
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            vec_out <= '0;
        end
        else if (vec_out.req && vec_ack_in)
        begin
            vec_out <= '0;
        end
        else if (!vec_out.req && any_cand && preempt_ok)
        begin
            vec_out.req    <= 1'b1;
            vec_out.high   <= cand_is_high;
            vec_out.vector <= `VEC_BASE
                + {9'h000, win, 3'h0};
        end
    end

    // [R17] [R9] active levels until return
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            high_active <= 1'b0;
            low_active  <= 1'b0;
        end
        else if (vec_out.req && vec_ack_in)
        begin
            if (vec_out.high)
            begin
                high_active <= 1'b1;
            end
            else
            begin
                low_active <= 1'b1;
            end
        end
        else if (reti_in)
        begin
            if (high_active)
            begin
                high_active <= 1'b0;
            end
            else
            begin
                low_active <= 1'b0;
            end
        end
    end

    assign active_level_out = {high_active, low_active};

    // ---------------------------------------------------------------
    // register read
    // ---------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sfr_rdata_out <= 8'h00;
            sfr_hit_out   <= 1'b0;
        end
        else
        begin
            sfr_hit_out <= 1'b1;
            case (sfr_in.addr)
                `ADDR_IRQ_ENABLE_MAIN:
                    sfr_rdata_out <= irq_enable_main;
                `ADDR_IRQ_PRIORITY_MAIN:
                    sfr_rdata_out <= irq_priority_main;
                `ADDR_PORT_IRQ_REQ_FLAGS:
                    sfr_rdata_out <= port_irq_request_flags;
                `ADDR_IRQ_ENABLE_PORT_ADC:
                    sfr_rdata_out <= irq_enable_port_adc;
                `ADDR_PORT_IRQ_POLARITY:
                    sfr_rdata_out <= port_irq_polarity;
                `ADDR_IRQ_PRIORITY_PORT_ADC:
                    sfr_rdata_out <= irq_priority_port_adc;
                default:
                begin
                    sfr_rdata_out <= 8'h00;
                    sfr_hit_out   <= 1'b0;
                end
            endcase
        end
    end

endmodule

// *** verif/irq_ctrl_checker.sv ***
`timescale 1ns/100ps
module irq_ctrl_checker
(
    input wire logic                   clk_in,
    input wire logic                   rst_n_in,
    input wire irq_ctrl_pkg::sfr_req_t sfr_in,
    input wire logic                   vec_ack_in,
    input wire logic                   reti_in,
    input wire logic                   sfr_hit_out,
    input wire irq_ctrl_pkg::vec_req_t vec_out,
    input wire logic [1:0]             active_level_out
);
    import irq_ctrl_pkg::*;
    // ----------
    // shadow registers
    // ----------
    logic [7:0]  en0, en1, pr0, pr1;
    logic [14:0] en, pr, en_d, pr_d;
    logic [3:0]  idx;
    assign en = {en1, en0[6:0]};
    assign pr = {pr1, pr0[6:0]};
    assign idx = vec_out.vector[6:3];
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            {en0, en1, pr0, pr1} <= 32'h0;
        else if (sfr_in.wr)
            case (sfr_in.addr)
                8'hA8: en0 <= sfr_in.wdata;
                8'hB8: pr0 <= sfr_in.wdata;
                8'hE8: en1 <= sfr_in.wdata;
                8'hF8: pr1 <= sfr_in.wdata;
                default: ;
            endcase
    end
    // values the arbiter saw at the launching edge
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            {en_d, pr_d} <= 30'h0;
        else
            {en_d, pr_d} <= {en, pr};
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    gate_block_a: assert property ($rose(vec_out.req) |-> $past(en0[7]))
        else $error("vector with gate off");
    src_enable_a: assert property ($rose(vec_out.req) |-> en_d[idx])
        else $error("vector of disabled source");
    level_match_a: assert property
        ($rose(vec_out.req) |-> vec_out.high == pr_d[idx])
        else $error("vector level wrong");
    req_stand_a: assert property
        (vec_out.req && !vec_ack_in |=> vec_out.req && $stable(vec_out.vector))
        else $error("vector dropped early");
    req_release_a: assert property (vec_out.req && vec_ack_in |=> !vec_out.req)
        else $error("vector kept after ack");
    nest_guard_a: assert property ($rose(vec_out.req) |->
        !active_level_out[1] && (vec_out.high || !active_level_out[0]))
        else $error("preempt not allowed");
    reti_pop_a: assert property (reti_in |=>
        active_level_out == {1'b0, $past(active_level_out) == 2'b11})
        else $error("return level wrong");
    hit_map_a: assert property (1'b1 |=> sfr_hit_out ==
        ($past(sfr_in.addr) inside {8'hA8, 8'hB8, 8'hC0, 8'hE8, 8'hE9, 8'hF8}))
        else $error("register hit wrong");
endmodule
bind irq_ctrl irq_ctrl_checker CHK (.clk_in, .rst_n_in, .sfr_in,
    .vec_ack_in, .reti_in, .sfr_hit_out, .vec_out, .active_level_out);

// *** verif/cpu_model.sv ***
`timescale 1ns/100ps
module cpu_model
(
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    input  wire irq_ctrl_pkg::vec_req_t vec_in,
    input  wire logic [2:0]             delay_in,
    input  wire logic                   ret_in,
    output logic                        ack_out,
    output logic                        reti_out
);
    import irq_ctrl_pkg::*;
    // ----------
    // core sequencer
    // ----------
    logic [2:0] wait_cnt;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ack_out  <= 1'b0;
            wait_cnt <= 3'h0;
        end
        else if (ack_out || !vec_in.req)
        begin
            ack_out  <= 1'b0;
            wait_cnt <= 3'h0;
        end
        else
        begin
            ack_out  <= (wait_cnt >= delay_in);
            wait_cnt <= wait_cnt + 3'h1;
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            reti_out <= 1'b0;
        else
            reti_out <= ret_in && !reti_out;
    end
endmodule

// *** verif/irq_ctrl_tb.sv ***
`timescale 1ns/100ps
module irq_ctrl_tb;
    import irq_ctrl_pkg::*;
    // ----------
    // bench
    // ----------
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b1;
    logic        ack, reti, hit, wake;
    logic        ret_go = 1'b0;
    logic [2:0]  dly = 3'h0;
    logic [6:0]  pol = 7'h00;
    logic [14:0] rq = 15'h0000;
    logic [7:0]  rdata, d;
    logic [1:0]  act;
    sfr_req_t    sfr = 17'h0;
    vec_req_t    vec;
    logic [16:0] exp_q[$];
    int          acks = 0, tgt = 0, checks = 0, fails = 0, cyc = 0;
    int          pl[15] = '{0, 5, 10, 1, 6, 11, 2, 7, 12, 3, 8, 13, 4, 9, 14};
    logic [7:0]  ad[6] = '{8'hA8, 8'hB8, 8'hC0, 8'hE8, 8'hE9, 8'hF8};
    logic [7:0]  mk[6] = '{8'hFF, 8'h7F, 8'h00, 8'hFF, 8'h7F, 8'hFF};
    always #12.5 clk_in = ~clk_in;
    irq_ctrl DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .sfr_in(sfr),
        .ext0_req_in(rq[0]), .tmr0_req_in(rq[1]), .ext1_req_in(rq[2]),
        .tmr1_req_in(rq[3]), .uart_req_in(rq[4]), .twowire_req_in(rq[5]),
        .tmr2_req_in(rq[6]), .adc_req_in(rq[14]),
        .port_one_lines_in(~(pol ^ rq[13:7])), .vec_ack_in(ack),
        .reti_in(reti), .sfr_rdata_out(rdata), .sfr_hit_out(hit),
        .vec_out(vec), .wake_out(wake), .active_level_out(act));
    cpu_model CORE (.clk_in(clk_in), .rst_n_in(rst_n_in), .vec_in(vec),
        .delay_in(dly), .ret_in(ret_go), .ack_out(ack), .reti_out(reti));
    task automatic results();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(string nm, logic [16:0] s, logic [16:0] e);
        checks++;
        if (s !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(negedge clk_in);
        sfr = {1'b1, a, v};
        @(negedge clk_in);
        sfr.wr = 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [8:0] e);
        @(negedge clk_in);
        sfr = {1'b0, a, 8'h00};
        @(negedge clk_in);
        check("register", 17'({hit, rdata}), 17'(e));
    endtask
    task automatic wait_ack();
        int t = 0;
        tgt++;
        while (acks < tgt && t < 40)
        begin
            @(negedge clk_in);
            t++;
        end
        check("ack count", 17'(acks), 17'(tgt));
    endtask
    task automatic ret();
        ret_go = 1'b1;
        @(negedge clk_in);
        ret_go = 1'b0;
        repeat (3) @(negedge clk_in);
    endtask
    task automatic pass_run(logic [14:0] enm, logic [14:0] prm);
        int q[$];
        for (int h = 1; h >= 0; h--)
            foreach (pl[k])
                if (enm[pl[k]] && prm[pl[k]] == 1'(h))
                begin
                    q.push_back(pl[k]);
                    exp_q.push_back({prm[pl[k]], 16'h0003 + 16'(pl[k] * 8)});
                end
        pol = 7'($urandom);
        dly = 3'($urandom);
        wr(8'hE9, {1'b0, pol});
        wr(8'hE8, enm[14:7]);
        wr(8'hB8, {1'b0, prm[6:0]});
        wr(8'hF8, prm[14:7]);
        wr(8'hA8, {1'b0, enm[6:0]});
        rq = 15'h7FFF;
        repeat (6) @(negedge clk_in);
        rd(8'hC0, {2'b10, enm[13:7]});
        check("wake", 17'(wake), 17'(|enm[13:7]));
        wr(8'hA8, {1'b1, enm[6:0]});
        foreach (q[k])
        begin
            wait_ack();
            rq[q[k]] = 1'b0;
            repeat (5) @(negedge clk_in);
            if (q[k] > 6 && q[k] < 14)
                wr(8'hC0, ~(8'h01 << (q[k] - 7)));
            ret();
        end
        repeat (10) @(negedge clk_in);
        rd(8'hC0, 9'h100);
        rq = 15'h0000;
        wr(8'hA8, 8'h00);
        wr(8'hE8, 8'h00);
        $display("test pass done");
    endtask
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            fails++;
            results();
        end
        if (vec.req === 1'b1 && ack === 1'b1)
        begin
            acks++;
            check("vector", {vec.high, vec.vector}, exp_q.pop_front());
        end
    end
    initial
    begin
        rst_n_in = 1'b0;
        void'($urandom(2816));
        repeat (8) @(negedge clk_in);
        rst_n_in = 1'b1;
        foreach (ad[k])
            rd(ad[k], 9'h100);
        rd(8'h80, 9'h000);
        foreach (ad[k])
        begin
            d = 8'($urandom);
            wr(ad[k], d);
            rd(ad[k], {1'b1, d & mk[k]});
            wr(ad[k], 8'h00);
        end
        $display("test registers done");
        pass_run(15'h7FFF, 15'h0000);
        pass_run(15'h7FFF, 15'h7FFF);
        repeat (2)
            pass_run(15'($urandom), 15'($urandom));
        wr(8'hB8, 8'h00);
        wr(8'hF8, 8'h80);
        wr(8'hE8, 8'h80);
        wr(8'hA8, 8'h81);
        exp_q.push_back({1'b0, 16'h0003});
        rq[0] = 1'b1;
        wait_ack();
        exp_q.push_back({1'b1, 16'h0073});
        rq[14] = 1'b1;
        wait_ack();
        rq = 15'h0000;
        repeat (3) @(negedge clk_in);
        check("active", 17'(act), 17'h3);
        ret();
        check("active", 17'(act), 17'h1);
        ret();
        check("active", 17'(act), 17'h0);
        check("queue", 17'(exp_q.size()), 17'h0);
        $display("test nesting done");
        results();
    end
endmodule
